// File: core/oerr_top.sv
// Purpose: fault reporting on pwm and encoder outputs, plus output angle
// Assumes: fault flags and raw angle arrive synchronous to aclk
// Notes: registers over AXI4-Lite; unmapped addresses answer SLVERR
`timescale 1ns/100ps
module oerr_top
    import oerr_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // fault detectors and angle path
    input wire oerr_pkg::oerr_fault_in_type fault_in,
    input wire logic [11:0] raw_angle,
    input wire logic [2:0] enc_in,
    input wire logic [2:0] enc_invert,
    input wire logic pwm_normal,
    // outputs
    output oerr_pkg::oerr_pins_type pins,
    output logic [11:0] out_angle,
    output logic low_power_disable
);
    import oerr_pkg::*;

    typedef struct packed {
        oerr_wstate_type wst;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] settings;
        logic [12:0] flt_en;
        logic [31:0] enc_cfg;
        logic [11:0] zero_offset;
        logic [12:0] pending;
        logic [12:0] once_shown;
        logic [10:0] cnt;
        logic [3:0] cur;
        logic cur_valid;
        oerr_pins_type pins;
        logic [11:0] angle;
    } oerr_state_type;

    oerr_state_type s_q;
    oerr_state_type s_d;

    logic [12:0] active;
    logic [12:0] report;
    logic [3:0] top_idx;
    logic top_valid;
    logic uv_now;
    logic enc_fault;
    logic [11:0] ang_off;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic wr_fire;
    logic [10:0] duty_thr;

    // ------------------------------------------------------------
    // fault condition gathering
    // ------------------------------------------------------------
    always_comb
    begin
        uv_now = (fault_in.analog_regulator_low & ~fault_in.uv_mask_analog)
            | (fault_in.supply_low & ~fault_in.uv_mask_supply);
        active = '0;
        active[OERR_F_OSC] = fault_in.osc_mismatch;
        active[OERR_F_MEM_U] = fault_in.mem_uncorrectable;
        active[OERR_F_SELFTEST] = fault_in.self_test;
        active[OERR_F_PLL] = fault_in.pll_unlocked;
        active[OERR_F_ZERO] = fault_in.zero_cross;
        active[OERR_F_AVG] = fault_in.averaging_span;
        active[OERR_F_UV] = uv_now;
        active[OERR_F_FLD_LO] = fault_in.field_low;
        active[OERR_F_MEM_C] = fault_in.memory_corrected;
        active[OERR_F_SAT] = fault_in.saturation;
        active[OERR_F_FLD_HI] = fault_in.field_high;
        active[OERR_F_TEMP] = fault_in.temperature_range;
        active[OERR_F_TOV] = fault_in.turns_overflow;
        // latched and once-only kinds live in pending, levels pass straight
        report = ((s_q.pending & (OERR_LATCHED | OERR_ONCE | (13'h0001 << OERR_F_TOV)))
            | (active & ~(OERR_LATCHED | OERR_ONCE | (13'h0001 << OERR_F_TOV))))
            & s_q.flt_en;
        top_valid = 1'b0;
        top_idx = '0;
        for (int i = OERR_NFLT - 1; i >= 0; i--)
        begin
            if (report[i])
            begin
                top_valid = 1'b1;
                top_idx = 4'(i);
            end
        end
        enc_fault = (s_q.enc_cfg[OERR_B_ENC_OSC] & fault_in.osc_mismatch)
            | (s_q.enc_cfg[OERR_B_ENC_PLL] & fault_in.pll_unlocked);
        ang_off = raw_angle - s_q.zero_offset;
        duty_thr = OERR_DUTY_TAB[s_q.cur];
    end

    // ------------------------------------------------------------
    // register write data merge
    // ------------------------------------------------------------
    always_comb
    begin
        wmask = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}}, {8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
        wval = s_q.w_data & wmask;
        wr_fire = (s_q.wst == OERR_W_IDLE) & s_q.aw_got & s_q.w_got;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        // axi write channel capture, either order
        if (s_axi_awvalid & ~s_q.aw_got & (s_q.wst == OERR_W_IDLE))
        begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid & ~s_q.w_got & (s_q.wst == OERR_W_IDLE))
        begin
            s_d.w_got = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        // pending faults: set wins over any clear in the same cycle
        if (s_q.cur_valid & (s_q.cnt == 11'h000) & OERR_ONCE[s_q.cur])
        begin
            s_d.pending[s_q.cur] = 1'b0;
        end
        case (s_q.wst)
            OERR_W_IDLE:
            begin
                if (wr_fire)
                begin
                    s_d.aw_got = 1'b0;
                    s_d.w_got = 1'b0;
                    s_d.bvalid = 1'b1;
                    s_d.bresp = OERR_RESP_OKAY;
                    s_d.wst = OERR_W_RESP;
                    case (s_q.aw_addr)
                        OERR_REG_SETTINGS: s_d.settings = (s_q.settings & ~wmask) | wval;
                        OERR_REG_FLT_EN: s_d.flt_en =
                            13'((s_q.flt_en & ~wmask[12:0]) | wval[12:0]);
                        OERR_REG_ENC_CFG: s_d.enc_cfg = (s_q.enc_cfg & ~wmask) | wval;
                        OERR_REG_OFFSET: s_d.zero_offset =
                            (s_q.zero_offset & ~wmask[11:0]) | wval[11:0];
                        OERR_REG_CTRL:
                        begin
                            if (wval[OERR_B_CLR_TOV])
                            begin
                                s_d.pending[OERR_F_TOV] = 1'b0;
                            end
                        end
                        OERR_REG_FAULTS, OERR_REG_REPORT, OERR_REG_ANGLE: ;
                        default: s_d.bresp = OERR_RESP_SLVERR;
                    endcase
                end
            end
            OERR_W_RESP:
            begin
                if (s_axi_bready)
                begin
                    s_d.bvalid = 1'b0;
                    s_d.wst = OERR_W_IDLE;
                end
            end
            default: s_d.wst = OERR_W_IDLE;
        endcase
        s_d.pending = s_d.pending | (active & (OERR_LATCHED | OERR_ONCE));
        s_d.pending[OERR_F_TOV] = s_d.pending[OERR_F_TOV] | fault_in.turns_overflow;
        // axi read
        s_d.arready = 1'b0;
        if (s_axi_arvalid & ~s_q.arready & ~s_q.rvalid)
        begin
            s_d.arready = 1'b1;
            s_d.rvalid = 1'b1;
            s_d.rresp = OERR_RESP_OKAY;
            case (s_axi_araddr)
                OERR_REG_SETTINGS: s_d.rdata = s_q.settings;
                OERR_REG_FLT_EN: s_d.rdata = {19'h00000, s_q.flt_en};
                OERR_REG_ENC_CFG: s_d.rdata = s_q.enc_cfg;
                OERR_REG_OFFSET: s_d.rdata = {20'h00000, s_q.zero_offset};
                OERR_REG_FAULTS: s_d.rdata = {19'h00000, report};
                OERR_REG_REPORT: s_d.rdata = {27'h0000000, s_q.cur_valid, s_q.cur};
                OERR_REG_ANGLE: s_d.rdata = {20'h00000, s_q.angle};
                OERR_REG_CTRL: s_d.rdata = 32'h00000000;
                default:
                begin
                    s_d.rdata = 32'h00000000;
                    s_d.rresp = OERR_RESP_SLVERR;
                end
            endcase
        end
        else if (s_q.rvalid & s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
        end
        // pwm fault carrier: period doubled, duty from the latched code
        if (s_q.cnt == OERR_DUTY_SCALE - 11'h001)
        begin
            s_d.cnt = 11'h000;
        end
        else
        begin
            s_d.cnt = s_q.cnt + 11'h001;
        end
        if (s_q.cnt == 11'h000)
        begin
            s_d.cur = top_idx; // code changes only on period boundaries
            s_d.cur_valid = top_valid;
        end
        s_d.pins.pwm_oe = 1'b1;
        s_d.pins.pwm_out = pwm_normal;
        if (s_q.settings[OERR_B_REPORT_EN] & top_valid)
        begin
            if (~s_q.settings[OERR_B_REPORT_SEL])
            begin
                s_d.pins.pwm_oe = 1'b0;
                s_d.pins.pwm_out = 1'b0;
            end
            else if (s_q.cur_valid)
            begin
                s_d.pins.pwm_out = (s_q.cnt < duty_thr);
            end
        end
        // encoder outputs forced high ahead of inversion
        s_d.pins.enc_out = (enc_fault ? 3'b111 : enc_in) ^ enc_invert;
        // angle pipeline
        s_d.angle = s_q.enc_cfg[OERR_B_HALF_TURN] ?
            12'(ang_off + OERR_HALF_TURN) : ang_off;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
            s_q.wst <= OERR_W_IDLE;
            s_q.pins.pwm_oe <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = s_q.aw_got;
    assign s_axi_wready = s_q.w_got;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign pins = s_q.pins;
    assign out_angle = s_q.angle;
    assign low_power_disable = s_q.settings[OERR_B_LOW_PWR_DIS];
endmodule // oerr_top

// File: core/oerr_pkg.sv
// Purpose: shared constants and carriers for the output fault reporting block
// Assumes: 32-bit AXI4-Lite register access, 12-bit angles
// Notes: duty codes are in 1/1600 steps of the carrier period
package oerr_pkg;
    localparam int unsigned OERR_NFLT = 13;
    localparam int unsigned OERR_ANG_W = 12;
    // register byte offsets
    localparam logic [7:0] OERR_REG_SETTINGS = 8'h00;
    localparam logic [7:0] OERR_REG_FLT_EN = 8'h04;
    localparam logic [7:0] OERR_REG_ENC_CFG = 8'h08;
    localparam logic [7:0] OERR_REG_OFFSET = 8'h0c;
    localparam logic [7:0] OERR_REG_FAULTS = 8'h10;
    localparam logic [7:0] OERR_REG_REPORT = 8'h14;
    localparam logic [7:0] OERR_REG_ANGLE = 8'h18;
    localparam logic [7:0] OERR_REG_CTRL = 8'h1c;
    // field positions
    localparam int unsigned OERR_B_REPORT_EN = 0;
    localparam int unsigned OERR_B_REPORT_SEL = 1;
    localparam int unsigned OERR_B_LOW_PWR_DIS = 20;
    localparam int unsigned OERR_B_ENC_PLL = 6;
    localparam int unsigned OERR_B_ENC_OSC = 7;
    localparam int unsigned OERR_B_HALF_TURN = 19;
    localparam int unsigned OERR_B_CLR_TOV = 0;
    // fault index = priority - 1
    localparam int unsigned OERR_F_OSC = 0;
    localparam int unsigned OERR_F_MEM_U = 1;
    localparam int unsigned OERR_F_SELFTEST = 2;
    localparam int unsigned OERR_F_PLL = 3;
    localparam int unsigned OERR_F_ZERO = 4;
    localparam int unsigned OERR_F_AVG = 5;
    localparam int unsigned OERR_F_UV = 6;
    localparam int unsigned OERR_F_FLD_LO = 7;
    localparam int unsigned OERR_F_MEM_C = 8;
    localparam int unsigned OERR_F_SAT = 9;
    localparam int unsigned OERR_F_FLD_HI = 10;
    localparam int unsigned OERR_F_TEMP = 11;
    localparam int unsigned OERR_F_TOV = 12;
    localparam logic [12:0] OERR_LATCHED = 13'h0007;
    localparam logic [12:0] OERR_ONCE = 13'h0120;
    // pwm carrier, normal period in clocks, halved carrier doubles it
    localparam logic [10:0] OERR_PWM_PERIOD = 11'h320;
    localparam logic [10:0] OERR_DUTY_SCALE = 11'h640;
    // duty in 1/1600 of the doubled period
    localparam logic [10:0] OERR_DUTY_TAB [13] = '{
        11'h050, 11'h0aa, 11'h104, 11'h15e, 11'h1b8, 11'h212, 11'h26c,
        11'h2c6, 11'h320, 11'h37a, 11'h3d4, 11'h42e, 11'h488};
    localparam logic [11:0] OERR_HALF_TURN = 12'h800;
    localparam logic [1:0] OERR_RESP_OKAY = 2'b00;
    localparam logic [1:0] OERR_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic osc_mismatch;
        logic mem_uncorrectable;
        logic self_test;
        logic pll_unlocked;
        logic zero_cross;
        logic averaging_span;
        logic analog_regulator_low;
        logic supply_low;
        logic uv_mask_analog;
        logic uv_mask_supply;
        logic field_low;
        logic memory_corrected;
        logic saturation;
        logic field_high;
        logic temperature_range;
        logic turns_overflow;
    } oerr_fault_in_type;

    typedef struct packed {
        logic pwm_out;
        logic pwm_oe;
        logic [2:0] enc_out;
    } oerr_pins_type;

    typedef enum logic [2:0] {
        OERR_W_IDLE = 3'b001,
        OERR_W_RESP = 3'b010,
        OERR_W_HOLD = 3'b100
    } oerr_wstate_type;
endpackage

// File: bench/oerr_host.sv
// Purpose: host side model that decodes the pwm pin
// Assumes: the host line has a pull-down, so a released pin reads low
// Notes: counts are taken from one rising edge to the next
`timescale 1ns/100ps
module oerr_host (
    // clock and pin
    input wire logic aclk,
    input wire logic pwm_out,
    input wire logic pwm_oe,
    // last complete period
    output logic [11:0] high_cnt,
    output logic [11:0] period_cnt
);
    logic [11:0] hi_q;
    logic [11:0] per_q;
    logic last_q;
    wire logic level = pwm_oe & pwm_out;
    always_ff @(posedge aclk)
    begin
        last_q <= level;
        if (level && !last_q)
        begin
            high_cnt <= hi_q;
            period_cnt <= per_q;
            hi_q <= 12'h001;
            per_q <= 12'h001;
        end
        else
        begin
            hi_q <= hi_q + {11'h000, level};
            per_q <= per_q + 12'h001;
        end
    end
endmodule // oerr_host

// File: bench/oerr_monitor.sv
// Purpose: concurrent checks on the ports of the fault reporting block
// Assumes: bound to oerr_top
// Notes: the angle check waits until register writes have settled
`timescale 1ns/100ps
module oerr_monitor
    import oerr_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire oerr_pkg::oerr_fault_in_type fault_in,
    input wire logic [11:0] raw_angle,
    input wire logic [2:0] enc_in,
    input wire logic [2:0] enc_invert,
    input wire oerr_pkg::oerr_pins_type pins,
    input wire logic [11:0] out_angle,
    input wire logic low_power_disable
);
    logic [1:0] quiet_q;
    logic [1:0] quiet_d;
    // ----------------------------------------
    // cycles since write traffic, saturating
    // ----------------------------------------
    always_comb
    begin
        quiet_d = quiet_q;
        if (s_axi_awvalid || s_axi_wvalid || s_axi_bvalid)
            quiet_d = 2'h0;
        else if (quiet_q != 2'h3)
            quiet_d = quiet_q + 2'h1;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            quiet_q <= 2'h0;
        else
            quiet_q <= quiet_d;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_PWM_FLOAT_LOW: assert property (!pins.pwm_oe |-> !pins.pwm_out)
        else $error("pwm high while released");
    AST_ENC_CAUSE: assert property ($past(aresetn) &&
        pins.enc_out != $past(enc_in ^ enc_invert)
        |-> $past(fault_in.osc_mismatch || fault_in.pll_unlocked))
        else $error("encoder disturbed without cause");
    AST_ENC_HIGH: assert property ($past(aresetn) &&
        pins.enc_out != $past(enc_in ^ enc_invert) |-> pins.enc_out == ~$past(enc_invert))
        else $error("encoder fault not all high");
    AST_ANGLE_TRACK: assert property (quiet_q == 2'h3 && $past(quiet_q) == 2'h3
        |-> out_angle - $past(out_angle) == $past(raw_angle) - $past(raw_angle, 2))
        else $error("angle does not follow raw");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_R_WITH_AR: assert property ($rose(s_axi_rvalid) |-> s_axi_arready)
        else $error("read answer without address accept");
    AST_LPD_QUIET: assert property ($changed(low_power_disable) |-> quiet_q != 2'h3)
        else $error("low power bit moved without a write");
endmodule // oerr_monitor
bind oerr_top oerr_monitor oerr_monitor_inst (.*);

// File: bench/testbench.sv
// Purpose: self-checking bench for the fault reporting block
// Assumes: bus tasks sample at the falling edge, drive after the rising one
// Notes: coded pwm is judged by the host model's counts
`timescale 1ns/100ps
module testbench;
    import oerr_pkg::*;
    localparam int FPOS [13] = '{15, 14, 13, 12, 11, 10, 9, 5, 4, 3, 2, 1, 0};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    oerr_fault_in_type fault_in = '0;
    logic [11:0] raw_angle = 12'h050;
    logic [2:0] enc_in = 3'h2;
    logic [2:0] enc_invert = 3'h4;
    logic pwm_normal = 1'b1;
    oerr_pins_type pins;
    logic [11:0] out_angle;
    logic low_power_disable;
    logic [11:0] high_cnt;
    logic [11:0] period_cnt;
    int n_mismatch = 0;
    int check_count = 0;
    always #25 aclk = ~aclk;
    oerr_top oerr_top_inst (.*);
    oerr_host oerr_host_inst (.aclk(aclk), .pwm_out(pins.pwm_out), .pwm_oe(pins.pwm_oe),
        .high_cnt(high_cnt), .period_cnt(period_cnt));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok = 1'b0;
        logic w_ok = 1'b0;
        logic bv;
        logic b_ok = 1'b0;
        logic [1:0] rsp;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!b_ok)
        begin
            @(negedge aclk);
            aw_ok = aw_ok | s_axi_awready;
            w_ok = w_ok | s_axi_wready;
            bv = s_axi_bvalid;
            b_ok = bv && s_axi_bready;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (aw_ok)
                s_axi_awvalid <= 1'b0;
            if (w_ok)
                s_axi_wvalid <= 1'b0;
            s_axi_bready <= bv && !b_ok;
        end
        check(32'({b_ok, rsp}), 32'({1'b1, er}));
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
        logic ar_ok;
        logic rv;
        logic r_ok = 1'b0;
        logic [1:0] rsp;
        logic [31:0] data;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!r_ok)
        begin
            @(negedge aclk);
            ar_ok = s_axi_arready;
            rv = s_axi_rvalid;
            r_ok = rv && s_axi_rready;
            rsp = s_axi_rresp;
            data = s_axi_rdata;
            @(posedge aclk);
            if (ar_ok)
                s_axi_arvalid <= 1'b0;
            s_axi_rready <= rv && !r_ok;
        end
        check(32'({r_ok, rsp}), 32'({1'b1, er}));
        check(data, ed);
    endtask
    task automatic t_regs();
        rd(OERR_REG_SETTINGS, OERR_RESP_OKAY, 32'h0);
        check(32'(pins.pwm_oe), 32'h1);
        wr(OERR_REG_SETTINGS, 32'h0010_0000, OERR_RESP_OKAY);
        rd(OERR_REG_SETTINGS, OERR_RESP_OKAY, 32'h0010_0000);
        check(32'(low_power_disable), 32'h1);
        rd(8'h40, OERR_RESP_SLVERR, 32'h0);
        wr(8'h40, 32'h1, OERR_RESP_SLVERR);
        pwm_normal <= 1'b0;
        fault_in.temperature_range <= 1'b1;
        wr(OERR_REG_FLT_EN, 32'h1fff, OERR_RESP_OKAY);
        settle(3);
        check(32'({pins.pwm_oe, pins.pwm_out}), 32'h2);
        @(posedge aclk);
        pwm_normal <= 1'b1;
        settle(3);
        check(32'({pins.pwm_oe, pins.pwm_out}), 32'h3);
        $display("regs done");
    endtask
    task automatic t_float();
        wr(OERR_REG_FLT_EN, 32'h0800, OERR_RESP_OKAY);
        wr(OERR_REG_SETTINGS, 32'h0010_0001, OERR_RESP_OKAY);
        settle(2);
        check(32'({pins.pwm_oe, pins.pwm_out}), 32'h0);
        wr(OERR_REG_FLT_EN, 32'h1000, OERR_RESP_OKAY);
        settle(2);
        check(32'({pins.pwm_oe, pins.pwm_out}), 32'h3);
        wr(OERR_REG_FLT_EN, 32'h0040, OERR_RESP_OKAY);
        fault_in.supply_low <= 1'b1;
        fault_in.uv_mask_supply <= 1'b1;
        settle(2);
        check(32'(pins.pwm_oe), 32'h1);
        @(posedge aclk);
        fault_in.uv_mask_supply <= 1'b0;
        settle(2);
        check(32'(pins.pwm_oe), 32'h0);
        @(posedge aclk);
        fault_in.supply_low <= 1'b0;
        wr(OERR_REG_FLT_EN, 32'h1000, OERR_RESP_OKAY);
        @(posedge aclk);
        fault_in.turns_overflow <= 1'b1;
        @(posedge aclk);
        fault_in.turns_overflow <= 1'b0;
        settle(3);
        check(32'(pins.pwm_oe), 32'h0);
        wr(OERR_REG_CTRL, 32'h1, OERR_RESP_OKAY);
        settle(2);
        check(32'(pins.pwm_oe), 32'h1);
        wr(OERR_REG_FLT_EN, 32'h0020, OERR_RESP_OKAY);
        fault_in.averaging_span <= 1'b1;
        @(posedge aclk);
        fault_in.averaging_span <= 1'b0;
        settle(3);
        check(32'(pins.pwm_oe), 32'h0);
        settle(3400);
        check(32'(pins.pwm_oe), 32'h1);
        $display("float done");
    endtask
    task automatic t_enc();
        wr(OERR_REG_ENC_CFG, 32'h40, OERR_RESP_OKAY);
        fault_in.pll_unlocked <= 1'b1;
        settle(2);
        check(32'(pins.enc_out), 32'h3);
        @(posedge aclk);
        fault_in.pll_unlocked <= 1'b0;
        settle(2);
        check(32'(pins.enc_out), 32'h6);
        wr(OERR_REG_ENC_CFG, 32'h0, OERR_RESP_OKAY);
        fault_in.pll_unlocked <= 1'b1;
        settle(2);
        check(32'(pins.enc_out), 32'h6);
        wr(OERR_REG_OFFSET, 32'h100, OERR_RESP_OKAY);
        settle(2);
        check(32'(out_angle), 32'hf50);
        wr(OERR_REG_ENC_CFG, 32'h0008_0000, OERR_RESP_OKAY);
        settle(2);
        check(32'(out_angle), 32'h750);
        rd(OERR_REG_ANGLE, OERR_RESP_OKAY, 32'h750);
        @(posedge aclk);
        raw_angle <= 12'h900;
        settle(2);
        check(32'(out_angle), 32'h000);
        $display("enc and angle done");
    endtask
    task automatic t_codes();
        wr(OERR_REG_FLT_EN, 32'h1fff, OERR_RESP_OKAY);
        wr(OERR_REG_SETTINGS, 32'h0010_0003, OERR_RESP_OKAY);
        fault_in <= '0;
        for (int i = 12; i >= 0; i--)
        begin
            @(posedge aclk);
            fault_in[FPOS[i]] <= 1'b1;
            // first code follows a steady high pin, so one more period passes before a count
            settle((i == 12) ? 5000 : 3400);
            check(32'(high_cnt), 32'(OERR_DUTY_TAB[i]));
            check(32'(period_cnt), 32'(OERR_PWM_PERIOD) * 32'h2);
        end
        wr(OERR_REG_ENC_CFG, 32'h80, OERR_RESP_OKAY);
        settle(2);
        check(32'(pins.enc_out), 32'h3);
        wr(OERR_REG_ENC_CFG, 32'h0, OERR_RESP_OKAY);
        settle(2);
        check(32'(pins.enc_out), 32'h6);
        @(posedge aclk);
        fault_in <= '0;
        settle(3400);
        check(32'(high_cnt), 32'(OERR_DUTY_TAB[0]));
        $display("codes done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_float();
        t_enc();
        t_codes();
        finish_test();
    end
    initial
    begin
        repeat (70000) @(posedge aclk);
        n_mismatch++;
        finish_test();
    end
endmodule // testbench
